// File: hw/ccdvs_top.sv
// Purpose: Builds the 13 vertical clock outputs and blanking for each line.
// Assumes: Registers arrive as static inputs; toggle sets for the selected
//          patterns arrive from the pattern store on the same clock.
// Notes:   Line and sequence marks are pins and pass two flip-flops first.
`timescale 1ns/1ps
`include "ccdvs_consts.svh"
module ccdvs_top
    import ccdvs_pkg::*;
#(
    parameter int NO  = `CCDVS_NUM_OUT,
    parameter int NT  = `CCDVS_NUM_TOG,
    parameter int PW  = `CCDVS_PIX_W,
    parameter int CW  = `CCDVS_CNT_W,
    parameter int SW  = `CCDVS_SEL_W
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             line_mark,                  // Line start pin
    input  wire logic             sequence_mark,              // Sequence start pin
    input  wire logic [SW-1:0]    group_a_pattern_select,
    input  wire logic [SW-1:0]    group_b_pattern_select,
    input  wire logic [1:0]       group_a_repeat_mode,
    input  wire logic [PW-1:0]    group_a_start_pixel,
    input  wire logic [PW-1:0]    group_b_start_pixel,
    input  wire logic [PW-1:0]    group_a_pattern_length,
    input  wire logic [PW-1:0]    group_b_pattern_length,
    input  wire logic [CW-1:0]    group_b_repeats_odd_line,
    input  wire logic [CW-1:0]    group_b_repeats_even_line,
    input  wire logic [CW-1:0]    group_a_repeats_slot_one,
    input  wire logic [CW-1:0]    group_a_repeats_slot_two,
    input  wire logic [CW-1:0]    group_a_repeats_slot_three,
    input  wire logic [CW-1:0]    group_a_repeats_slot_four,
    input  wire logic [PW-1:0]    mask_window_one_begin,
    input  wire logic [PW-1:0]    mask_window_one_end,
    input  wire logic [PW-1:0]    mask_window_two_begin,
    input  wire logic [PW-1:0]    mask_window_two_end,
    input  wire logic [1:0]       mask_mode,
    input  wire logic             hold_select,
    input  wire logic [CW-1:0]    insert_pattern_line,
    input  wire logic             insert_pattern_enable,
    input  wire logic [NO-1:0]    output_group_assign,         // Bit 0 is output 1
    input  wire logic             combine_groups,
    input  wire logic [NO-1:0]    vertical_out_start_polarity,
    input  wire logic             blanking_alternate,
    input  wire logic [NT*PW-1:0] blanking_toggles,           // Toggle k at [k*PW]
    input  wire logic [NO*NT*PW-1:0] group_a_toggles,         // Per output, per toggle
    input  wire logic [NO*NT*PW-1:0] group_b_toggles,
    output logic [SW-1:0]         pattern_a_index_ff,          // Pattern store lookup
    output logic [SW-1:0]         pattern_b_index_ff,
    output logic [NO-1:0]         vertical_out_ff,             // Vertical clocks
    output logic                  horizontal_blanking_ff,
    output logic                  odd_line_ff                  // High on odd lines
);
    // True when the pattern position meets a live toggle of the set
    function automatic logic tog_hit(input logic [NT*PW-1:0] togs,
                                     input logic [PW-1:0]    pos,
                                     input logic [NT-1:0]    use_mask);
        logic             hit;
        logic [PW-1:0]    tp;
        hit = 1'b0;
        for (int k = 0; k < NT; k++) begin
            tp = togs[k*PW +: PW];
            // Positions 0 and 8191 never toggle
            if (use_mask[k] && tp == pos && tp != `CCDVS_TOG_IGN_LO
                && tp != `CCDVS_TOG_IGN_HI) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    logic          line_s1_ff, line_s2_ff, line_s3_ff;  // Line pin synchroniser
    logic          seq_s1_ff, seq_s2_ff, seq_s3_ff;     // Sequence pin synchroniser
    logic          line_start;                          // Line rising edge
    logic          seq_start;                           // Sequence rising edge
    logic [PW-1:0] pixel_ff;                            // Pixel in line
    logic [CW-1:0] line_ff;                             // Line in sequence
    logic [1:0]    slot_ff;                             // Alternation slot
    logic          seq_pend_ff;                         // Next line is first
    logic          win_one_ff, win_two_ff;              // Mask windows open
    logic          masked;                              // Toggles ignored
    logic          hold_stall;                          // Group A position frozen
    logic          insert_line;                         // Second pattern line
    logic [CW-1:0] nxt_rep_a, nxt_rep_b;                // Counts for this line
    logic          act_a, act_b, rs_a, rs_b;            // Engine status
    logic [PW-1:0] off_a, off_b;                        // Engine positions
    logic          b_uses_own;                          // Group B runs its own start

    // Line and sequence pins: two flip-flops, then a third for edges
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            line_s1_ff <= 1'b0;
            line_s2_ff <= 1'b0;
            line_s3_ff <= 1'b0;
            seq_s1_ff  <= 1'b0;
            seq_s2_ff  <= 1'b0;
            seq_s3_ff  <= 1'b0;
        end else begin
            line_s1_ff <= line_mark;
            line_s2_ff <= line_s1_ff;
            line_s3_ff <= line_s2_ff;
            seq_s1_ff  <= sequence_mark;
            seq_s2_ff  <= seq_s1_ff;
            seq_s3_ff  <= seq_s2_ff;
        end
    end

    assign line_start = line_s2_ff & ~line_s3_ff;
    assign seq_start  = seq_s2_ff & ~seq_s3_ff;

    // Pixel counter restarts each line
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pixel_ff <= '0;
        end else if (line_start) begin
            pixel_ff <= '0;
        end else if (pixel_ff != `CCDVS_TOG_IGN_HI) begin
            pixel_ff <= PW'(pixel_ff + 1'b1);
        end
    end

    // Sequence mark arms a restart taken at the next line start
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seq_pend_ff <= 1'b1;
        end else if (seq_start) begin
            seq_pend_ff <= 1'b1;
        end else if (line_start) begin
            seq_pend_ff <= 1'b0;
        end
    end

    // Line number and alternation slot, wrapping by mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            line_ff     <= '0;
            slot_ff     <= 2'h0;
            odd_line_ff <= 1'b1;
        end else if (line_start) begin
            if (seq_pend_ff) begin
                // First line of a sequence is slot one and odd
                line_ff     <= '0;
                slot_ff     <= 2'h0;
                odd_line_ff <= 1'b1;
            end else begin
                line_ff     <= CW'(line_ff + 1'b1);
                odd_line_ff <= ~odd_line_ff;
                if (slot_ff >= group_a_repeat_mode) begin
                    slot_ff <= 2'h0;
                end else begin
                    slot_ff <= 2'(slot_ff + 1'b1);
                end
            end
        end
    end

    // Repeat counts: the count changes per line; the pattern changes only on the insertion line
    always_comb begin
        case (slot_ff)
            2'h0:    nxt_rep_a = group_a_repeats_slot_one;
            2'h1:    nxt_rep_a = group_a_repeats_slot_two;
            2'h2:    nxt_rep_a = group_a_repeats_slot_three;
            default: nxt_rep_a = group_a_repeats_slot_four;
        endcase
        // Group B alternates odd and even lines
        nxt_rep_b = odd_line_ff ? group_b_repeats_odd_line
                                : group_b_repeats_even_line;
    end

    // Pattern store lookups follow the selectors
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pattern_a_index_ff <= '0;
            pattern_b_index_ff <= '0;
        end else begin
            pattern_a_index_ff <= group_a_pattern_select;
            pattern_b_index_ff <= group_b_pattern_select;
        end
    end

    // Mask windows open at begin pixel and close at end pixel
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            win_one_ff <= 1'b0;
            win_two_ff <= 1'b0;
        end else if (line_start) begin
            win_one_ff <= 1'b0;
            win_two_ff <= 1'b0;
        end else begin
            if (pixel_ff == mask_window_one_end) begin
                win_one_ff <= 1'b0;
            end else if (pixel_ff == mask_window_one_begin) begin
                win_one_ff <= mask_mode[`CCDVS_MASK_ONE_BIT];
            end
            if (pixel_ff == mask_window_two_end) begin
                win_two_ff <= 1'b0;
            end else if (pixel_ff == mask_window_two_begin) begin
                win_two_ff <= mask_mode[`CCDVS_MASK_TWO_BIT];
            end
        end
    end

    assign masked      = win_one_ff | win_two_ff;
    assign hold_stall  = masked & hold_select;
    assign insert_line = insert_pattern_enable
                         && line_ff == insert_pattern_line;
    assign b_uses_own  = !combine_groups;

    // Group A engine: its start, length and slot count
    ccdvs_rep_engine #(.PW(PW), .CW(CW)) u_eng_a (
        .clk          (clk),
        .nrst         (nrst),
        .line_start   (line_start),
        .stall        (hold_stall),
        .pixel        (pixel_ff),
        .start        (group_a_start_pixel),
        .length       (group_a_pattern_length),
        .repeats      (nxt_rep_a),
        .active       (act_a),
        .rep_start_ff (rs_a),
        .offset_ff    (off_a)
    );

    // Group B engine; on the insertion line it places the second pattern
    ccdvs_rep_engine #(.PW(PW), .CW(CW)) u_eng_b (
        .clk          (clk),
        .nrst         (nrst),
        .line_start   (line_start),
        .stall        (1'b0),
        .pixel        (pixel_ff),
        .start        (group_b_start_pixel),
        .length       (group_b_pattern_length),
        .repeats      (nxt_rep_b),
        .active       (act_b),
        .rep_start_ff (rs_b),
        .offset_ff    (off_b)
    );

    // Vertical outputs: polarity at each repetition, then toggles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vertical_out_ff <= '0;
        end else begin
            for (int i = 0; i < NO; i++) begin
                if (combine_groups) begin
                    // Both toggle sets on group A timing and polarity
                    if (rs_a && !masked) begin
                        vertical_out_ff[i] <= vertical_out_start_polarity[i];
                    end else if (act_a && !masked
                        && (tog_hit(group_a_toggles[i*NT*PW +: NT*PW], off_a, '1)
                        ||  tog_hit(group_b_toggles[i*NT*PW +: NT*PW], off_a, '1))) begin
                        vertical_out_ff[i] <= ~vertical_out_ff[i];
                    end
                end else if (insert_line) begin
                    // Group A pattern on every output, plus the inserted second pattern
                    if (rs_a && !masked) begin
                        vertical_out_ff[i] <= vertical_out_start_polarity[i];
                    end else if (!masked
                        && ((act_a && tog_hit(group_a_toggles[i*NT*PW +: NT*PW],
                                              off_a, '1))
                        ||  (act_b && tog_hit(group_b_toggles[i*NT*PW +: NT*PW],
                                              off_b, '1)))) begin
                        vertical_out_ff[i] <= ~vertical_out_ff[i];
                    end
                end else if (output_group_assign[i] && b_uses_own) begin
                    // Output assigned to group B; a window also blocks the reload
                    if (rs_b && !masked) begin
                        vertical_out_ff[i] <= vertical_out_start_polarity[i];
                    end else if (act_b && !masked
                        && tog_hit(group_b_toggles[i*NT*PW +: NT*PW], off_b, '1)) begin
                        vertical_out_ff[i] <= ~vertical_out_ff[i];
                    end
                end else begin
                    // Output on group A, the default with assign at zero
                    if (rs_a && !masked) begin
                        vertical_out_ff[i] <= vertical_out_start_polarity[i];
                    end else if (act_a && !masked
                        && tog_hit(group_a_toggles[i*NT*PW +: NT*PW], off_a, '1)) begin
                        vertical_out_ff[i] <= ~vertical_out_ff[i];
                    end
                end
            end
        end
    end

    // Blanking: all six toggles, or split by odd and even line
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            horizontal_blanking_ff <= `CCDVS_BLANK_RST;
        end else if (line_start) begin
            horizontal_blanking_ff <= `CCDVS_BLANK_RST;
        end else if (tog_hit(blanking_toggles, pixel_ff,
                     !blanking_alternate ? 6'h3f
                     : (odd_line_ff ? 6'h03 : 6'h3c))) begin
            horizontal_blanking_ff <= ~horizontal_blanking_ff;
        end
    end

    // Masked outputs stay put across a whole window
    a_mask_freezes: assert property (@(posedge clk) disable iff (!nrst)
        masked |=> vertical_out_ff == $past(vertical_out_ff))
        else $error("output moved inside mask window");

    // Mode zero keeps slot one on every line
    a_slot_single: assert property (@(posedge clk) disable iff (!nrst)
        group_a_repeat_mode == `CCDVS_MODE_SINGLE && $stable(group_a_repeat_mode)
        && line_start |=> slot_ff == 2'h0)
        else $error("slot moved in single mode");

    // Slot never passes the mode's wrap point
    a_slot_wrap: assert property (@(posedge clk) disable iff (!nrst)
        line_start && !seq_pend_ff && slot_ff >= group_a_repeat_mode
        |=> slot_ff == 2'h0)
        else $error("slot failed to wrap");

    // A sequence restart makes the next line odd and slot one
    a_seq_restart: assert property (@(posedge clk) disable iff (!nrst)
        line_start && seq_pend_ff |=> (odd_line_ff && slot_ff == 2'h0 && line_ff == '0))
        else $error("sequence restart not applied");

    // Hold freezes the group A position
    a_hold_stalls: assert property (@(posedge clk) disable iff (!nrst)
        hold_stall && act_a && !line_start |=> off_a == $past(off_a))
        else $error("hold did not freeze pattern position");

    // Odd and even alternate on consecutive lines
    a_odd_even: assert property (@(posedge clk) disable iff (!nrst)
        line_start && !seq_pend_ff |=> odd_line_ff != $past(odd_line_ff))
        else $error("odd and even failed to alternate");

    // Window one follows mask mode bit zero
    a_win_enable: assert property (@(posedge clk) disable iff (!nrst)
        !mask_mode[`CCDVS_MASK_ONE_BIT] && $stable(mask_mode) && !win_one_ff
        |=> !win_one_ff)
        else $error("window one opened while disabled");
endmodule

// File: hw/ccdvs_consts.svh
// Purpose: Constants for the CCD vertical-sequence generator.
// Assumes: Included by its bare name from the package and the modules.
// Notes:   Offsets are pixel or line positions; widths follow the register map.
`ifndef CCDVS_CONSTS_SVH
`define CCDVS_CONSTS_SVH

`define CCDVS_PIX_W        13
`define CCDVS_CNT_W        12
`define CCDVS_NUM_OUT      13
`define CCDVS_NUM_TOG      6
`define CCDVS_SEL_W        5
`define CCDVS_TOG_IGN_LO   13'h0000
`define CCDVS_TOG_IGN_HI   13'h1fff
`define CCDVS_MODE_SINGLE  2'h0
`define CCDVS_MODE_TWO     2'h1
`define CCDVS_MODE_THREE   2'h2
`define CCDVS_MODE_FOUR    2'h3
`define CCDVS_MASK_ONE_BIT 0
`define CCDVS_MASK_TWO_BIT 1
`define CCDVS_BLANK_RST    1'h1

`endif

// File: hw/ccdvs_pkg.sv
// Purpose: Types shared by the vertical-sequence generator modules.
// Assumes: Constants come from the header.
// Notes:   Engine states are Gray coded along idle, run, done.
`include "ccdvs_consts.svh"
package ccdvs_pkg;
    // Repetition engine state
    typedef enum logic [1:0] {
        CCDVS_IDLE = 2'h0,
        CCDVS_RUN  = 2'h1,
        CCDVS_DONE = 2'h3
    } ccdvs_eng_e;
    // One pixel position
    typedef logic [`CCDVS_PIX_W-1:0] ccdvs_pix_t;
endpackage

// File: hw/ccdvs_rep_engine.sv
// Purpose: Runs one pattern group: start pixel, length and repeats in a line.
// Assumes: pixel counts up from zero after each line_start pulse.
// Notes:   A repeat count of 0 or 1 gives one pass; a zero length gives none.
`timescale 1ns/1ps
`include "ccdvs_consts.svh"
module ccdvs_rep_engine
    import ccdvs_pkg::*;
#(
    parameter int PW = `CCDVS_PIX_W,
    parameter int CW = `CCDVS_CNT_W
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          line_start,   // Restart for the new line
    input  wire logic          stall,        // Hold area: freeze position
    input  wire logic [PW-1:0] pixel,        // Current pixel of the line
    input  wire logic [PW-1:0] start,        // Pattern start pixel
    input  wire logic [PW-1:0] length,       // Pixels per repetition
    input  wire logic [CW-1:0] repeats,      // Repetitions this line
    output logic               active,       // Pattern running
    output logic               rep_start_ff, // First pixel of a repetition
    output logic [PW-1:0]      offset_ff     // Position inside the pattern
);
    ccdvs_eng_e    state_ff;  // Engine state
    logic [CW-1:0] reps_ff;   // Completed repetitions

    assign active = (state_ff == CCDVS_RUN);

    // Pattern walk through the line
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff     <= CCDVS_IDLE;
            reps_ff      <= '0;
            offset_ff    <= '0;
            rep_start_ff <= 1'b0;
        end else begin
            rep_start_ff <= 1'b0;
            if (line_start) begin
                // New line: wait again for the start pixel
                state_ff  <= CCDVS_IDLE;
                reps_ff   <= '0;
                offset_ff <= '0;
            end else begin
                case (state_ff)
                    CCDVS_IDLE: begin
                        if (pixel == start && length != '0) begin
                            state_ff     <= CCDVS_RUN;
                            offset_ff    <= '0;
                            rep_start_ff <= 1'b1;
                        end
                    end
                    CCDVS_RUN: begin
                        if (!stall) begin
                            if (offset_ff == PW'(length - 1'b1)) begin
                                if (CW'(reps_ff + 1'b1) >= repeats) begin
                                    state_ff <= CCDVS_DONE;
                                end else begin
                                    // Next repetition one length later
                                    reps_ff      <= CW'(reps_ff + 1'b1);
                                    offset_ff    <= '0;
                                    rep_start_ff <= 1'b1;
                                end
                            end else begin
                                offset_ff <= PW'(offset_ff + 1'b1);
                            end
                        end
                    end
                    CCDVS_DONE: begin
                        state_ff <= CCDVS_DONE;
                    end
                    default: begin
                        state_ff <= CCDVS_IDLE;
                    end
                endcase
            end
        end
    end

    // Position never reaches the length while running
    a_offset_in_length: assert property (@(posedge clk) disable iff (!nrst)
        active |-> offset_ff < length)
        else $error("pattern offset past length");

    // Repetition starts from offset zero while running
    a_rep_from_zero: assert property (@(posedge clk) disable iff (!nrst)
        rep_start_ff |-> (offset_ff == '0 && active))
        else $error("repetition did not start at offset zero");
endmodule

// File: tb/ccdvs_ccd_model.sv
// Purpose: Stand-in for the CCD vertical clock inputs; counts transfer pulses.
// Assumes: Fed by the registered vertical outputs on the pixel clock.
// Notes:   Counts rising edges on phases 1 and 13 until clr clears them.
`timescale 1ns/1ps
module ccdvs_ccd_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        clr,      // Start a fresh line count
    input  wire logic [12:0] v_in,     // Vertical clock levels
    output logic [7:0]       cnt_a,    // Pulses seen on phase 1
    output logic [7:0]       cnt_b     // Pulses seen on phase 13
);
    logic [12:0] prev_ff;              // Levels one clock earlier
    // Each rising edge moves the charge one step, so count them
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_ff <= 13'h0000;
            cnt_a   <= 8'h00;
            cnt_b   <= 8'h00;
        end else begin
            prev_ff <= v_in;
            cnt_a   <= clr ? 8'h00 : cnt_a + 8'(v_in[0] & ~prev_ff[0]);
            cnt_b   <= clr ? 8'h00 : cnt_b + 8'(v_in[12] & ~prev_ff[12]);
        end
    end
endmodule

// File: tb/tb_top.sv
// Purpose: Random line traffic; checks pulses per line for both groups.
// Assumes: Pattern starts at pixel 10, length 8, toggles at 2 and 4.
// Notes:   Repeat counts are drawn 0 to 4; zero counts as one pass.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, nrst = 1'b0, line_mark = 1'b0, sequence_mark = 1'b0, clr = 1'b0;
    logic [4:0] group_a_pattern_select = 5'h03, group_b_pattern_select = 5'h07;
    logic [1:0] group_a_repeat_mode = 2'h0, mask_mode = 2'h0;
    logic [12:0] group_a_start_pixel = 13'h000a, group_b_start_pixel = 13'h000a;
    logic [12:0] group_a_pattern_length = 13'h0008, group_b_pattern_length = 13'h0008;
    logic [12:0] mask_window_one_begin = 13'h000c, mask_window_one_end = 13'h000f;
    logic [12:0] mask_window_two_begin = 13'h0049, mask_window_two_end = 13'h004a;
    logic [11:0] group_b_repeats_odd_line, group_b_repeats_even_line, insert_pattern_line;
    logic [11:0] group_a_repeats_slot_one, group_a_repeats_slot_two;
    logic [11:0] group_a_repeats_slot_three, group_a_repeats_slot_four;
    logic hold_select = 1'b0, insert_pattern_enable = 1'b0, combine_groups = 1'b0;
    logic blanking_alternate = 1'b0, horizontal_blanking_ff, odd_line_ff;
    logic [12:0] output_group_assign = 13'h1000, vertical_out_start_polarity = 13'h0000;
    logic [12:0] vertical_out_ff;
    logic [77:0] blanking_toggles = {39'h0, 13'h0028, 13'h001e, 13'h0014};
    logic [1013:0] group_a_toggles = '0, group_b_toggles = '0;
    logic [4:0] pattern_a_index_ff, pattern_b_index_ff;
    logic [7:0] cnt_a, cnt_b;
    logic [31:0] seed = 32'h0000_0041;     // Fixed start of the xorshift stream
    int n_mismatch = 0, check_count = 0;
    always #25 clk = ~clk;                 // 20 MHz pixel clock
    ccdvs_top dut (.clk, .nrst, .line_mark, .sequence_mark, .group_a_pattern_select,
        .group_b_pattern_select, .group_a_repeat_mode, .group_a_start_pixel,
        .group_b_start_pixel, .group_a_pattern_length, .group_b_pattern_length,
        .group_b_repeats_odd_line, .group_b_repeats_even_line, .group_a_repeats_slot_one,
        .group_a_repeats_slot_two, .group_a_repeats_slot_three, .group_a_repeats_slot_four,
        .mask_window_one_begin, .mask_window_one_end, .mask_window_two_begin,
        .mask_window_two_end, .mask_mode, .hold_select, .insert_pattern_line,
        .insert_pattern_enable, .output_group_assign, .combine_groups,
        .vertical_out_start_polarity, .blanking_alternate, .blanking_toggles,
        .group_a_toggles, .group_b_toggles, .pattern_a_index_ff, .pattern_b_index_ff,
        .vertical_out_ff, .horizontal_blanking_ff, .odd_line_ff);
    ccdvs_ccd_model ccd (.clk(clk), .nrst(nrst), .clr(clr), .v_in(vertical_out_ff),
        .cnt_a(cnt_a), .cnt_b(cnt_b));
    // Xorshift source of repeat counts and modes
    function automatic logic [11:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return 12'(seed % 5);
    endfunction
    // Pulses per line: a count of zero still gives one pass
    function automatic logic [7:0] reps(input logic [11:0] v);
        return (v == 12'h000) ? 8'h01 : v[7:0];
    endfunction
    // Group A count for line k of the sequence, by repetition mode
    function automatic logic [11:0] slot_cnt(input int k);
        case (k % (group_a_repeat_mode + 1))
            0: return group_a_repeats_slot_one;
            1: return group_a_repeats_slot_two;
            2: return group_a_repeats_slot_three;
            default: return group_a_repeats_slot_four;
        endcase
    endfunction
    // Pulses on phase 1 (grp_b low) or phase 13: window one eats the first pass
    function automatic logic [7:0] exp_cnt(input int k, input logic grp_b);
        logic [7:0] a, b, m;
        a = reps(slot_cnt(k));
        b = reps(k % 2 ? group_b_repeats_even_line : group_b_repeats_odd_line);
        m = {7'h00, mask_mode[0]};
        // Insertion line: both groups toggle every output
        if (insert_pattern_enable && !combine_groups && k == insert_pattern_line)
            return ((a > b) ? a : b) - m;
        // Group B never holds, so it loses the pass
        if (grp_b && !combine_groups)
            return b - m;
        // Hold resumes group A where it stopped
        return hold_select ? a : a - m;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] expct);
        check_count++;
        if (seen !== expct) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expct);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One line: mark held 4 clocks, pattern done well before the next mark
    task automatic run_line(input int k);
        @(posedge clk) begin line_mark <= 1'b1; clr <= 1'b1; end
        @(posedge clk) clr <= 1'b0;
        repeat (3) @(posedge clk);
        line_mark <= 1'b0;
        repeat (75) @(posedge clk);
        check(cnt_a, exp_cnt(k, 1'b0));
        check(cnt_b, exp_cnt(k, 1'b1));
        check({7'h00, horizontal_blanking_ff}, {7'h00, blanking_alternate && k % 2 == 0});
        check({7'h00, odd_line_ff}, {7'h00, k % 2 == 0});
    endtask
    initial begin
        for (int i = 0; i < 13; i++) begin
            group_a_toggles[(i*6)*13 +: 13] = 13'h0002;
            group_a_toggles[(i*6+1)*13 +: 13] = 13'h0004;
        end
        group_b_toggles = group_a_toggles;
        insert_pattern_line = 12'h002;
        repeat (10) @(posedge clk);
        check({vertical_out_ff[7:0]}, 8'h00);
        check({6'h00, horizontal_blanking_ff, odd_line_ff}, 8'h03);
        nrst <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            @(posedge clk) begin
                group_a_repeat_mode <= (s < 4) ? 2'(s) : 2'(rnd());
                {group_a_repeats_slot_one, group_a_repeats_slot_two} <= {rnd(), rnd()};
                {group_a_repeats_slot_three, group_a_repeats_slot_four} <= {rnd(), rnd()};
                {group_b_repeats_odd_line, group_b_repeats_even_line} <= {rnd(), rnd()};
                sequence_mark <= 1'b1;
                {blanking_alternate, hold_select, combine_groups} <= {s[0], s[2], s[2] & s[1]};
                {mask_mode, insert_pattern_enable} <= {2'(s), s[1] & ~s[2]};
            end
            repeat (4) @(posedge clk);
            sequence_mark <= 1'b0;
            for (int k = 0; k < 5; k++) run_line(k);
        end
        check({pattern_b_index_ff, pattern_a_index_ff[2:0]}, 8'h3b);
        complete_run();
    end
endmodule
